// file: cspc_top.sv
// Configuration sequencer with status and handshake pin control
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Busy-high output driven High from reset until I/O go active.
// - Busy-low output driven Low until I/O go active, then user I/O.
// - Init pin held Low during power stabilisation and memory clearing.
// - External Low on init pin keeps device waiting; no configuration start.
// - Master modes wait 30 to 300 us more after init goes High.
// - Init pin driven Low during configuration on a data error.
// - After I/O go active, init pin becomes ordinary user I/O.
// - Without scan primitive, scan functions disabled after configuration.
// - Mode select inputs sampled after init goes High to pick mode.
// - Low reprogram input clears memory and starts new configuration.
module cspc_top (
    // ------------------------------------------------------------------
    // Clock, reset and configuration control
    // ------------------------------------------------------------------
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        PROGRAM_B_I,
    input  wire logic        INIT_I,
    input  wire logic [2:0]  CFG_MODE_SELECT_I,
    input  wire logic        CFG_DATA_ERROR_I,
    input  wire logic        CFG_DONE_I,
    input  wire logic        SCAN_ENABLE_PRIMITIVE_I,
    // ------------------------------------------------------------------
    // User values after I/O go active
    // ------------------------------------------------------------------
    input  wire logic        USER_BUSY_HIGH_I,
    input  wire logic        USER_BUSY_HIGH_OE_I,
    input  wire logic        USER_BUSY_LOW_I,
    input  wire logic        USER_BUSY_LOW_OE_I,
    input  wire logic        USER_INIT_I,
    input  wire logic        USER_INIT_OE_I,
    // ------------------------------------------------------------------
    // Pin and status outputs
    // ------------------------------------------------------------------
    output logic             CFG_BUSY_HIGH_OUT_O,
    output logic             CFG_BUSY_HIGH_OUT_OE_O,
    output logic             CFG_BUSY_LOW_OUT_O,
    output logic             CFG_BUSY_LOW_OUT_OE_O,
    output logic             INIT_O,
    output logic             INIT_OE_O,
    output logic             SCAN_ENABLE_O,
    output logic             CFG_START_O,
    output logic [2:0]       CFG_MODE_O,
    output logic             IO_ACTIVE_O
);
    import cspc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        cspc_state_t       st;
        logic [CNT_W-1:0]  cnt;
        logic [2:0]        mode;
        logic              err;
        logic              start;
    } cspc_seq_t;

    localparam logic [CNT_W-1:0] POWER_LAST = CNT_W'(POWER_STAB_CYC - 1);
    localparam logic [CNT_W-1:0] CLEAR_LAST = CNT_W'(CLEAR_CYC - 1);
    localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(WAIT_MIN_CYC - 1);

    cspc_seq_t s;
    cspc_seq_t next_s;

    cspc_pin_if pins ();

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic cnt_at(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] last_val);
        return (cnt == last_val);
    endfunction : cnt_at

    function automatic logic holds_init(input cspc_state_t st);
        return (st == ST_POWER) || (st == ST_CLEAR);
    endfunction : holds_init

    function automatic logic configuring(input cspc_state_t st);
        return (st == ST_CONFIG);
    endfunction : configuring

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_s       = s;
        next_s.start = 1'b0;
        next_s.cnt   = s.cnt + CNT_W'(1);
        // Reprogram overrides every state
        if (!PROGRAM_B_I) begin
            next_s.st  = ST_CLEAR;
            next_s.cnt = '0;
            next_s.err = 1'b0;
        end else begin
            unique case (s.st)
                // Power stabilisation, init held low
                ST_POWER: begin
                    if (cnt_at(s.cnt, POWER_LAST)) begin
                        next_s.st  = ST_CLEAR;
                        next_s.cnt = '0;
                    end
                end

                // Memory clearing, init held low
                ST_CLEAR: begin
                    if (cnt_at(s.cnt, CLEAR_LAST)) begin
                        next_s.st  = ST_WAIT;
                        next_s.cnt = '0;
                    end
                end

                // Waiting for init released
                ST_WAIT: begin
                    next_s.cnt = '0;
                    if (INIT_I) begin
                        next_s.mode = CFG_MODE_SELECT_I;
                        if (cspc_is_master(CFG_MODE_SELECT_I)) begin
                            next_s.st = ST_DELAY;
                        end else begin
                            next_s.st    = ST_CONFIG;
                            next_s.start = 1'b1;
                        end
                    end
                end

                // Master mode extra wait
                ST_DELAY: begin
                    if (!INIT_I) begin
                        next_s.st  = ST_WAIT;
                        next_s.cnt = '0;
                    end else if (cnt_at(s.cnt, DELAY_LAST)) begin
                        next_s.st    = ST_CONFIG;
                        next_s.start = 1'b1;
                        next_s.cnt   = '0;
                    end
                end

                // Error is sticky until reprogram
                ST_CONFIG: begin
                    next_s.cnt = '0;
                    if (CFG_DATA_ERROR_I) begin
                        next_s.err = 1'b1;
                    end
                    if (CFG_DONE_I && !s.err && !CFG_DATA_ERROR_I) begin
                        next_s.st = ST_ACTIVE;
                    end
                end

                // I/O active, pins under user control
                ST_ACTIVE: begin
                    next_s.cnt = '0;
                end

                // Illegal codes restart power-up
                default: begin
                    next_s.st  = ST_POWER;
                    next_s.cnt = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sequencer register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s <= '{st:    ST_POWER,
                   cnt:   '0,
                   mode:  MODE_RESET_VALUE,
                   err:   1'b0,
                   start: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------
    assign pins.io_active  = (s.st == ST_ACTIVE);
    assign pins.init_hold  = holds_init(s.st);
    assign pins.init_error = configuring(s.st) && s.err;
    assign pins.scan_used  = SCAN_ENABLE_PRIMITIVE_I;
    assign pins.in_config  = configuring(s.st);

    // ------------------------------------------------------------------
    // Pin multiplexer
    // ------------------------------------------------------------------
    cspc_pin_mux cspc_pin_mux_i (
        .clk_i               (CLK_I),
        .rst_b_i             (RST_B_I),
        .pins                (pins),
        .user_busy_high_i    (USER_BUSY_HIGH_I),
        .user_busy_high_oe_i (USER_BUSY_HIGH_OE_I),
        .user_busy_low_i     (USER_BUSY_LOW_I),
        .user_busy_low_oe_i  (USER_BUSY_LOW_OE_I),
        .user_init_i         (USER_INIT_I),
        .user_init_oe_i      (USER_INIT_OE_I),
        .busy_high_o         (CFG_BUSY_HIGH_OUT_O),
        .busy_high_oe_o      (CFG_BUSY_HIGH_OUT_OE_O),
        .busy_low_o          (CFG_BUSY_LOW_OUT_O),
        .busy_low_oe_o       (CFG_BUSY_LOW_OUT_OE_O),
        .init_o              (INIT_O),
        .init_oe_o           (INIT_OE_O),
        .scan_enable_o       (SCAN_ENABLE_O)
    );

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    assign CFG_START_O = s.start;
    assign CFG_MODE_O  = s.mode;
    assign IO_ACTIVE_O = pins.io_active;
endmodule : cspc_top
`default_nettype wire

// file: cspc_pkg.sv
// Package of constants and types for the configuration status pin controller
package cspc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 40;
    localparam int WAIT_MIN_US         = 30;
    localparam int WAIT_MAX_US         = 300;
    localparam int WAIT_MIN_CYC        = (WAIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_MAX_CYC        = (WAIT_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int POWER_STAB_CYC      = 16;
    localparam int CLEAR_CYC           = 64;
    localparam int CNT_W               = 13;

    // ------------------------------------------------------------------
    // Mode select encoding
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
    localparam logic [2:0] MODE_RESET_VALUE   = 3'h7;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POWER   = 3'b000,
        ST_CLEAR   = 3'b001,
        ST_WAIT    = 3'b010,
        ST_DELAY   = 3'b011,
        ST_CONFIG  = 3'b100,
        ST_ACTIVE  = 3'b101
    } cspc_state_t;

    // Master modes have mode select bit 0 low
    function automatic logic cspc_is_master(input logic [2:0] mode);
        return (mode[0] == 1'b0);
    endfunction : cspc_is_master

endpackage : cspc_pkg

// file: cspc_pin_if.sv
// Interface carrying pin control between sequencer and pin mux
`timescale 1ns/1ps
`default_nettype none
interface cspc_pin_if;
    logic io_active;
    logic init_hold;
    logic init_error;
    logic scan_used;
    logic in_config;

    modport seq (output io_active, output init_hold, output init_error,
                 output scan_used, output in_config);
    modport mux (input io_active, input init_hold, input init_error,
                 input scan_used, input in_config);
endinterface : cspc_pin_if
`default_nettype wire

// file: cspc_pin_mux.sv
// Pin multiplexer between configuration signalling and user I/O
`timescale 1ns/1ps
`default_nettype none
module cspc_pin_mux (
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    cspc_pin_if.mux     pins,
    input  wire logic   user_busy_high_i,
    input  wire logic   user_busy_high_oe_i,
    input  wire logic   user_busy_low_i,
    input  wire logic   user_busy_low_oe_i,
    input  wire logic   user_init_i,
    input  wire logic   user_init_oe_i,
    output logic        busy_high_o,
    output logic        busy_high_oe_o,
    output logic        busy_low_o,
    output logic        busy_low_oe_o,
    output logic        init_o,
    output logic        init_oe_o,
    output logic        scan_enable_o
);
    import cspc_pkg::*;

    typedef struct packed {
        logic bh;
        logic bh_oe;
        logic bl;
        logic bl_oe;
        logic ini;
        logic ini_oe;
        logic scan;
    } cspc_mux_t;

    cspc_mux_t r;
    cspc_mux_t next_r;

    // ------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (pins.io_active) begin
            next_r.bh     = user_busy_high_i;
            next_r.bh_oe  = user_busy_high_oe_i;
            next_r.bl     = user_busy_low_i;
            next_r.bl_oe  = user_busy_low_oe_i;
            next_r.ini    = user_init_i;
            next_r.ini_oe = user_init_oe_i;
            next_r.scan   = pins.scan_used;
        end else begin
            next_r.bh     = 1'b1;
            next_r.bh_oe  = 1'b1;
            next_r.bl     = 1'b0;
            next_r.bl_oe  = 1'b1;
            next_r.ini    = 1'b0;
            next_r.ini_oe = pins.init_hold | (pins.in_config & pins.init_error);
            next_r.scan   = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '{bh: 1'b1, bh_oe: 1'b1, bl: 1'b0, bl_oe: 1'b1,
                   ini: 1'b0, ini_oe: 1'b1, scan: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign busy_high_o    = r.bh;
    assign busy_high_oe_o = r.bh_oe;
    assign busy_low_o     = r.bl;
    assign busy_low_oe_o  = r.bl_oe;
    assign init_o         = r.ini;
    assign init_oe_o      = r.ini_oe;
    assign scan_enable_o  = r.scan;
endmodule : cspc_pin_mux
`default_nettype wire

// file: cspc_top_chk.sv
// Checker of configuration status pin behaviour
`timescale 1ns/1ps
`default_nettype none
module cspc_top_chk (
    input wire logic       CLK_I,
    input wire logic       RST_B_I,
    input wire logic       PROGRAM_B_I,
    input wire logic       INIT_I,
    input wire logic [2:0] CFG_MODE_SELECT_I,
    input wire logic       CFG_DATA_ERROR_I,
    input wire logic       SCAN_ENABLE_PRIMITIVE_I,
    input wire logic       USER_INIT_OE_I,
    input wire logic       USER_BUSY_HIGH_I,
    input wire logic       USER_BUSY_LOW_I,
    input wire logic       CFG_BUSY_HIGH_OUT_O,
    input wire logic       CFG_BUSY_LOW_OUT_O,
    input wire logic       INIT_OE_O,
    input wire logic       SCAN_ENABLE_O,
    input wire logic       CFG_START_O,
    input wire logic [2:0] CFG_MODE_O,
    input wire logic       IO_ACTIVE_O
);
    logic [6:0]  rcnt;
    logic [12:0] hcnt;
    logic        in_cfg;
    // ----
    // Cycles since reset, init high run
    // ----
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rcnt   <= 7'h0;
            hcnt   <= 13'h0;
            in_cfg <= 1'b0;
        end else begin
            rcnt   <= (rcnt == 7'h7f) ? rcnt : rcnt + 7'h1;
            hcnt   <= !INIT_I ? 13'h0 : (hcnt == 13'h1fff) ? hcnt : hcnt + 13'h1;
            in_cfg <= (in_cfg | CFG_START_O) & ~IO_ACTIVE_O & PROGRAM_B_I;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    AST_BUSY_HIGH: assert property (!IO_ACTIVE_O && !$past(IO_ACTIVE_O) |-> CFG_BUSY_HIGH_OUT_O)
        else $error("busy high released early");
    AST_BUSY_LOW: assert property (!IO_ACTIVE_O && !$past(IO_ACTIVE_O) |-> !CFG_BUSY_LOW_OUT_O)
        else $error("busy low released early");
    AST_INIT_HOLD: assert property (rcnt < 7'h50 |-> INIT_OE_O)
        else $error("init released during clearing");
    AST_WAIT_HOLD: assert property (!INIT_I |=> !CFG_START_O)
        else $error("start while init low");
    AST_MASTER_DELAY: assert property (CFG_START_O && !CFG_MODE_O[0] |-> hcnt inside {[13'h2ee:13'h1d4e]})
        else $error("master delay out of range");
    AST_DATA_ERROR: assert property (in_cfg && !IO_ACTIVE_O && CFG_DATA_ERROR_I && PROGRAM_B_I |-> ##[1:2] INIT_OE_O)
        else $error("data error not flagged");
    AST_INIT_USER: assert property (IO_ACTIVE_O && $past(IO_ACTIVE_O) |-> INIT_OE_O == $past(USER_INIT_OE_I))
        else $error("init not user controlled");
    AST_SCAN_OFF: assert property (IO_ACTIVE_O && $past(IO_ACTIVE_O) |-> SCAN_ENABLE_O == $past(SCAN_ENABLE_PRIMITIVE_I))
        else $error("scan enable wrong after configuration");
    AST_MODE_LATCH: assert property (CFG_START_O && CFG_MODE_O[0] |-> CFG_MODE_O == $past(CFG_MODE_SELECT_I))
        else $error("mode not latched");
    AST_REPROGRAM: assert property (!PROGRAM_B_I |=> !IO_ACTIVE_O ##1 INIT_OE_O)
        else $error("reprogram did not restart");
    AST_RELEASE_ALL: assert property ($rose(IO_ACTIVE_O) |=>
        CFG_BUSY_HIGH_OUT_O == $past(USER_BUSY_HIGH_I) &&
        CFG_BUSY_LOW_OUT_O == $past(USER_BUSY_LOW_I) &&
        INIT_OE_O == $past(USER_INIT_OE_I))
        else $error("busy outputs and init not released together");
    COV_SLAVE: cover property (CFG_START_O && CFG_MODE_O[0]);
    COV_MASTER: cover property (CFG_START_O && !CFG_MODE_O[0]);
    COV_ACTIVE: cover property ($rose(IO_ACTIVE_O));
endmodule : cspc_top_chk
bind cspc_top cspc_top_chk cspc_top_chk_i (.*);
`default_nettype wire

// file: cspc_host_model.sv
// Host and board model: pulled-up init wire and reprogram request
`timescale 1ns/1ps
`default_nettype none
module cspc_host_model (
    input  wire logic init_oe_i,
    input  wire logic init_out_i,
    input  wire logic hold_low_i,
    input  wire logic prog_req_i,
    output logic      init_wire_o,
    output logic      program_b_o
);
    // Open drain with pull-up; host may hold it low
    assign init_wire_o = hold_low_i ? 1'b0 : (init_oe_i ? init_out_i : 1'b1);
    assign program_b_o = ~prog_req_i;
endmodule : cspc_host_model
`default_nettype wire

// file: cspc_top_bench.sv
// Testbench of the configuration status pin controller
`timescale 1ns/1ps
`default_nettype none
module cspc_top_bench;
    logic       CLK_I, RST_B_I, CFG_DATA_ERROR_I, CFG_DONE_I, SCAN_ENABLE_PRIMITIVE_I;
    logic       USER_BUSY_HIGH_I, USER_BUSY_HIGH_OE_I, USER_BUSY_LOW_I, USER_BUSY_LOW_OE_I;
    logic       USER_INIT_I, USER_INIT_OE_I, hold, prog, CFG_START_O, IO_ACTIVE_O;
    logic       CFG_BUSY_HIGH_OUT_O, CFG_BUSY_HIGH_OUT_OE_O, CFG_BUSY_LOW_OUT_O;
    logic       CFG_BUSY_LOW_OUT_OE_O, INIT_O, INIT_OE_O, SCAN_ENABLE_O;
    logic [2:0] CFG_MODE_SELECT_I, CFG_MODE_O;
    wire        INIT_I, PROGRAM_B_I;
    int         mismatches = 0, checked = 0, waited;
    cspc_top cspc_top_i (.*);
    cspc_host_model cspc_host_model_i (.init_oe_i(INIT_OE_O), .init_out_i(INIT_O),
        .hold_low_i(hold), .prog_req_i(prog), .init_wire_o(INIT_I), .program_b_o(PROGRAM_B_I));
    initial begin
        CLK_I = 1'b0;
        forever #20 CLK_I = ~CLK_I;
    end
    task automatic final_report();
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_hi(input int sel, input int lim);
        waited = 0;
        while (((sel == 0) ? CFG_START_O : IO_ACTIVE_O) !== 1'b1) begin
            @(posedge CLK_I);
            #1;
            waited++;
            if (waited > lim) begin
                mismatches++;
                final_report();
            end
        end
    endtask : wait_hi
    task automatic restart(input logic [2:0] mode);
        @(posedge CLK_I);
        prog <= 1'b1;
        hold <= 1'b1;
        CFG_DONE_I <= 1'b0;
        CFG_MODE_SELECT_I <= mode;
        @(posedge CLK_I);
        prog <= 1'b0;
        #1;
        chk(IO_ACTIVE_O, 1'b0);
        repeat (100) @(posedge CLK_I);
        hold <= 1'b0;
    endtask : restart
    task automatic sc_power_hold();
        for (int i = 0; i < 100; i++) begin
            @(posedge CLK_I);
            #1;
            if (i < cspc_pkg::POWER_STAB_CYC + cspc_pkg::CLEAR_CYC) chk(INIT_OE_O, 1'b1);
            chk({CFG_BUSY_HIGH_OUT_O, CFG_BUSY_LOW_OUT_O, CFG_START_O}, 3'h4);
        end
        @(posedge CLK_I);
        hold <= 1'b0;
    endtask : sc_power_hold
    task automatic sc_slave();
        wait_hi(0, 8);
        chk({CFG_MODE_O, SCAN_ENABLE_O}, 4'h3);
        @(posedge CLK_I);
        CFG_DONE_I <= 1'b1;
        wait_hi(1, 8);
        @(posedge CLK_I);
        #1;
        chk({CFG_BUSY_HIGH_OUT_O, CFG_BUSY_HIGH_OUT_OE_O, CFG_BUSY_LOW_OUT_O, CFG_BUSY_LOW_OUT_OE_O}, 4'h6);
        chk({INIT_O, INIT_OE_O, SCAN_ENABLE_O}, 3'h6);
    endtask : sc_slave
    task automatic sc_error();
        restart(3'h1);
        wait_hi(0, 8);
        @(posedge CLK_I);
        CFG_DATA_ERROR_I <= 1'b1;
        CFG_DONE_I <= 1'b1;
        @(posedge CLK_I);
        CFG_DATA_ERROR_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
        #1;
        chk({IO_ACTIVE_O, INIT_OE_O, INIT_I}, 3'h2);
    endtask : sc_error
    task automatic sc_master();
        restart(3'h0);
        SCAN_ENABLE_PRIMITIVE_I <= 1'b1;
        wait_hi(0, 7600);
        chk(waited >= cspc_pkg::WAIT_MIN_CYC && waited <= cspc_pkg::WAIT_MAX_CYC + 2, 1'b1);
        chk(CFG_MODE_O, 3'h0);
        @(posedge CLK_I);
        CFG_DONE_I <= 1'b1;
        wait_hi(1, 8);
        repeat (2) @(posedge CLK_I);
        #1;
        chk(SCAN_ENABLE_O, 1'b1);
    endtask : sc_master
    initial begin
        RST_B_I <= 1'b0;
        hold <= 1'b1;
        prog <= 1'b0;
        CFG_MODE_SELECT_I <= 3'h1;
        CFG_DATA_ERROR_I <= 1'b0;
        CFG_DONE_I <= 1'b0;
        SCAN_ENABLE_PRIMITIVE_I <= 1'b0;
        {USER_BUSY_HIGH_I, USER_BUSY_HIGH_OE_I, USER_BUSY_LOW_I, USER_BUSY_LOW_OE_I} <= 4'h6;
        {USER_INIT_I, USER_INIT_OE_I} <= 2'h3;
        repeat (12) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        sc_power_hold();
        sc_slave();
        sc_error();
        sc_master();
        final_report();
    end
endmodule : cspc_top_bench
`default_nettype wire
